// ==== src/pnpb_pkg.sv ====
// Package for the next-page and line-coding control register bank.
// Assumes a 32-bit APB slave on a single clock; all offsets are word indices.
package pnpb_pkg;

  // Register word indices; byte address is four times the index
  localparam logic [5:0] NP_TX_IDX   = 6'h0E;
  localparam logic [5:0] LP_NP_IDX   = 6'h10;
  localparam logic [5:0] AUX_IDX     = 6'h20;
  localparam logic [5:0] EXP_IDX     = 6'h0C;
  localparam logic [5:0] IRQ_STS_IDX = 6'h24;
  localparam logic [5:0] IRQ_MSK_IDX = 6'h25;

  // Next-page word fields
  localparam int NP_MORE_BIT   = 15;
  localparam int NP_RSVD_BIT   = 14;
  localparam int NP_MSG_BIT    = 13;
  localparam int NP_COMPLY_BIT = 12;
  localparam int NP_TOGGLE_BIT = 11;
  localparam int NP_CODE_MSB   = 10;
  localparam int NP_CODE_W     = 11;

  // Auxiliary control fields
  localparam int AUX_TX_DIS_BIT  = 13;
  localparam int AUX_BYP_4B5B    = 10;
  localparam int AUX_BYP_SCR     = 9;
  localparam int AUX_BYP_NRZI    = 8;
  localparam int AUX_BYP_ALIGN   = 7;
  localparam int AUX_BLW_OFF     = 6;
  localparam int AUX_FEF_BIT     = 5;
  localparam int AUX_EXT_FIFO    = 2;

  // Expansion and interrupt fields
  localparam int EXP_PAGE_RCVD_BIT = 1;
  localparam int IRQ_PAGE_RCVD_BIT = 0;
  localparam int IRQ_PAGE_SENT_BIT = 1;
  localparam int IRQ_W             = 2;

  // Reset values
  localparam logic [15:0] NP_TX_RST  = 16'h2001;
  localparam logic [15:0] LP_NP_RST  = 16'h0000;
  localparam logic [15:0] AUX_RST    = 16'h0000;
  localparam logic [1:0]  IRQ_RST    = 2'h0;
  // Mask of bits software may write in the outgoing next-page word
  localparam logic [15:0] NP_TX_WMASK = 16'hB7FF;

  typedef struct packed {
    logic [4:0] code;
    logic       delim_insert;
    logic       valid;
  } pnpb_tx_sym_t;

  typedef struct packed {
    logic [3:0] rxd;
    logic       rxer;
    logic       crs;
  } pnpb_rx_out_t;

  typedef struct packed {
    logic [15:0]      np_tx;
    logic [15:0]      lp_np;
    logic [15:0]      aux;
    logic             page_rcvd;
    logic [IRQ_W-1:0] irq_sts;
    logic [IRQ_W-1:0] irq_msk;
    logic [31:0]      prdata;
    pnpb_tx_sym_t     tx_sym;
    pnpb_rx_out_t     rx_out;
  } pnpb_state_t;

endpackage

// ==== src/pnpb_regs.sv ====
// Next-page transmit/receive registers and 100BASE-X line-coding control.
// Assumes APB master, auto-negotiation arbiter and PCS datapath on CLOCK_I.
//
// What this block does
// - Outgoing page bit 15 software-writable more-pages flag, reset 0.
// - Outgoing page bit 13 software-writable message-page flag, reset 1.
// - Outgoing page bit 12 software-writable comply flag, reset 0.
// - Outgoing bit 11 read-only, reset 0, inverted between distinct sent pages.
// - Bits 10:0 hold an 11-bit message or unformatted code.
// - Partner next page exposed read-only, same layout, resets to 0.
// - Aux bit 13 disables transmitter; line output goes high impedance.
// - Aux bit 10 routes raw 5-bit TXER/TXD codes to scrambler, no delimiters.
// - Bypass puts descrambled aligned codes on RXER/RXD; CRS on valid frame.
// - Aux bit 9 disables scrambler and descrambler, reset 0.
// - Aux bit 8 bypasses NRZI/MLT3 coding, sending plain NRZ.
// - Aux bit 7 stops symbol alignment; with aux bit 10 set, unaligned codes reach RXER/RXD.
// - Aux bit 6 turns baseline wander correction off; default on.
// - Aux bit 5 enables far-end fault function.
// - Aux bit 2 selects extended receive FIFO mode, default 0.
// - Page-received flag latches on new partner word until read or reset.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module pnpb_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic              CLOCK_I,
  input  wire logic              RST_N_I,
  // APB slave
  input  wire logic              PSEL_I,
  input  wire logic              PENABLE_I,
  input  wire logic              PWRITE_I,
  input  wire logic [ADDR_W-1:0] PADDR_I,
  input  wire logic [31:0]       PWDATA_I,
  input  wire logic [3:0]        PSTRB_I,
  output logic      [31:0]       PRDATA_O,
  output logic                   PREADY_O,
  output logic                   PSLVERR_O,
  output logic                   IRQ_O,
  // Auto-negotiation arbiter side
  input  wire logic              LP_PAGE_VALID_I,
  input  wire logic [15:0]       LP_PAGE_I,
  input  wire logic              NP_SENT_I,
  output logic      [15:0]       NP_TX_WORD_O,
  // Line-coding controls
  output logic                   LINE_TX_OE_N_O,
  output logic                   BYPASS_SCRAMBLER_O,
  output logic                   BYPASS_NRZI_O,
  output logic                   BYPASS_ALIGN_O,
  output logic                   BLW_CORR_OFF_O,
  output logic                   FAR_END_FAULT_ON_O,
  output logic                   EXT_RX_FIFO_O,
  // Transmit symbol path
  input  wire logic              TXEN_I,
  input  wire logic              TXER_I,
  input  wire logic [3:0]        TXD_I,
  input  wire logic [4:0]        ENC_CODE_I,
  input  wire logic              ENC_VALID_I,
  output logic      [4:0]        SCR_CODE_O,
  output logic                   SCR_VALID_O,
  output logic                   DELIM_INSERT_O,
  // Receive symbol path
  input  wire logic [4:0]        RX_CODE_ALIGNED_I,
  input  wire logic [4:0]        RX_CODE_RAW_I,
  input  wire logic              RX_FRAME_VALID_I,
  input  wire logic [3:0]        DEC_RXD_I,
  input  wire logic              DEC_RXER_I,
  input  wire logic              DEC_CRS_I,
  output logic      [3:0]        RXD_O,
  output logic                   RXER_O,
  output logic                   CRS_O
);

  pnpb_pkg::pnpb_state_t st_ff;
  pnpb_pkg::pnpb_state_t nxt_st;

  logic       setup_ph;
  logic       access_ph;
  logic       addr_ok;
  logic [5:0] idx;
  logic       hit_np_tx;
  logic       hit_lp_np;
  logic       hit_aux;
  logic       hit_exp;
  logic       hit_sts;
  logic       hit_msk;
  logic       mapped;
  logic       wr_en;
  logic       rd_en;
  logic [15:0] wr_lane;
  logic [15:0] rd_word;
  logic [pnpb_pkg::IRQ_W-1:0] irq_evt;
  logic        bypass_4b5b;
  logic        bypass_align;
  logic [4:0]  rx_code;

  assign setup_ph  = PSEL_I && !PENABLE_I;
  assign access_ph = PSEL_I && PENABLE_I;
  assign idx       = PADDR_I[7:2];
  // Upper address bits must be zero; a shift stays legal at any bus width
  assign addr_ok   = (PADDR_I[1:0] == 2'h0) && ((PADDR_I >> 8) == '0);

  always_comb begin
    hit_np_tx = 1'b0;
    hit_lp_np = 1'b0;
    hit_aux   = 1'b0;
    hit_exp   = 1'b0;
    hit_sts   = 1'b0;
    hit_msk   = 1'b0;
    if (addr_ok) begin
      case (idx)
        pnpb_pkg::NP_TX_IDX: begin
          hit_np_tx = 1'b1;
        end
        pnpb_pkg::LP_NP_IDX: begin
          hit_lp_np = 1'b1;
        end
        pnpb_pkg::AUX_IDX: begin
          hit_aux = 1'b1;
        end
        pnpb_pkg::EXP_IDX: begin
          hit_exp = 1'b1;
        end
        pnpb_pkg::IRQ_STS_IDX: begin
          hit_sts = 1'b1;
        end
        pnpb_pkg::IRQ_MSK_IDX: begin
          hit_msk = 1'b1;
        end
        default: begin
          hit_np_tx = 1'b0;
        end
      endcase
    end
  end

  assign mapped    = hit_np_tx || hit_lp_np || hit_aux || hit_exp || hit_sts || hit_msk;
  assign wr_en     = access_ph && PWRITE_I && mapped;
  assign rd_en     = access_ph && !PWRITE_I && mapped;

  // Zero wait states; read data was captured in the setup cycle
  assign PREADY_O  = access_ph;
  assign PSLVERR_O = access_ph && !mapped;
  assign PRDATA_O  = st_ff.prdata;
  assign IRQ_O     = |(st_ff.irq_sts & st_ff.irq_msk);

  // Byte strobes gate the two low lanes
  assign wr_lane = {{8{PSTRB_I[1]}}, {8{PSTRB_I[0]}}};

  assign irq_evt[pnpb_pkg::IRQ_PAGE_RCVD_BIT] = LP_PAGE_VALID_I;
  assign irq_evt[pnpb_pkg::IRQ_PAGE_SENT_BIT] = NP_SENT_I;

  assign bypass_4b5b  = st_ff.aux[pnpb_pkg::AUX_BYP_4B5B];
  assign bypass_align = st_ff.aux[pnpb_pkg::AUX_BYP_ALIGN];

  // Alignment bypass only reaches the pins when the code path is raw
  assign rx_code = bypass_align ? RX_CODE_RAW_I : RX_CODE_ALIGNED_I;

  logic                       np_wr;
  logic                       aux_wr;
  logic                       sts_wr;
  logic                       msk_wr;
  logic                       exp_rd;
  logic                       rd_setup;
  logic [15:0]                np_wmask;
  logic [15:0]                np_merged;
  logic [15:0]                aux_merged;
  logic [pnpb_pkg::IRQ_W-1:0] sts_kept;
  logic                       toggle_nxt;
  logic                       tx_disable;
  logic                       byp_scr;
  logic                       byp_nrzi;
  logic                       blw_off;
  logic                       fef_on;
  logic                       ext_fifo;

  // Per-register strobes, qualified once
  assign np_wr    = wr_en && hit_np_tx;
  assign aux_wr   = wr_en && hit_aux;
  assign sts_wr   = wr_en && hit_sts && PSTRB_I[0];
  assign msk_wr   = wr_en && hit_msk && PSTRB_I[0];
  assign exp_rd   = rd_en && hit_exp;
  assign rd_setup = setup_ph && !PWRITE_I;

  // Bits 14 and 11 never take software data
  assign np_wmask  = pnpb_pkg::NP_TX_WMASK & wr_lane;
  assign np_merged = (st_ff.np_tx & ~np_wmask) | (PWDATA_I[15:0] & np_wmask);

  // Reserved aux bits are stored as written; software keeps them default
  assign aux_merged = (st_ff.aux & ~wr_lane) | (PWDATA_I[15:0] & wr_lane);

  // Toggle flips once per page handed over, ready for the next one
  assign toggle_nxt = st_ff.np_tx[pnpb_pkg::NP_TOGGLE_BIT] ^ NP_SENT_I;

  // Write one to clear; events are merged afterwards so they win
  assign sts_kept = sts_wr ? (st_ff.irq_sts & ~PWDATA_I[pnpb_pkg::IRQ_W-1:0]) : st_ff.irq_sts;

  always_comb begin
    rd_word = 16'h0000;
    case (1'b1)
      hit_np_tx: begin
        rd_word = st_ff.np_tx;
      end
      hit_lp_np: begin
        rd_word = st_ff.lp_np;
      end
      hit_aux: begin
        rd_word = st_ff.aux;
      end
      hit_exp: begin
        rd_word[pnpb_pkg::EXP_PAGE_RCVD_BIT] = st_ff.page_rcvd;
      end
      hit_sts: begin
        rd_word[pnpb_pkg::IRQ_W-1:0] = st_ff.irq_sts;
      end
      hit_msk: begin
        rd_word[pnpb_pkg::IRQ_W-1:0] = st_ff.irq_msk;
      end
      default: begin
        rd_word = 16'h0000;
      end
    endcase
  end

  always_comb begin
    nxt_st = st_ff;

    // Read data held from setup so the access cycle answers at once
    if (rd_setup) begin
      nxt_st.prdata = {16'h0000, rd_word};
    end

    // Outgoing next page: software bits, fixed reserved bit, hardware toggle
    if (np_wr) begin
      nxt_st.np_tx = np_merged;
    end
    nxt_st.np_tx[pnpb_pkg::NP_RSVD_BIT]   = 1'b0;
    nxt_st.np_tx[pnpb_pkg::NP_TOGGLE_BIT] = toggle_nxt;

    // Partner page copied whole on each checked, acknowledged word
    if (LP_PAGE_VALID_I) begin
      nxt_st.lp_np = LP_PAGE_I;
    end

    if (aux_wr) begin
      nxt_st.aux = aux_merged;
    end

    // Clear on read, but a page arriving in the same cycle wins
    if (exp_rd) begin
      nxt_st.page_rcvd = 1'b0;
    end
    if (LP_PAGE_VALID_I) begin
      nxt_st.page_rcvd = 1'b1;
    end

    nxt_st.irq_sts = sts_kept | irq_evt;
    if (msk_wr) begin
      nxt_st.irq_msk = PWDATA_I[pnpb_pkg::IRQ_W-1:0];
    end

    // Transmit symbol selection into the scrambler
    case (bypass_4b5b)
      1'b1: begin
        nxt_st.tx_sym.code         = {TXER_I, TXD_I};
        nxt_st.tx_sym.delim_insert = 1'b0;
        nxt_st.tx_sym.valid        = TXEN_I;
      end
      default: begin
        nxt_st.tx_sym.code         = ENC_CODE_I;
        nxt_st.tx_sym.delim_insert = 1'b1;
        nxt_st.tx_sym.valid        = ENC_VALID_I;
      end
    endcase

    // Receive pins carry raw codes when the decoder is bypassed
    case (bypass_4b5b)
      1'b1: begin
        nxt_st.rx_out.rxer = rx_code[4];
        nxt_st.rx_out.rxd  = rx_code[3:0];
        nxt_st.rx_out.crs  = RX_FRAME_VALID_I;
      end
      default: begin
        nxt_st.rx_out.rxer = DEC_RXER_I;
        nxt_st.rx_out.rxd  = DEC_RXD_I;
        nxt_st.rx_out.crs  = DEC_CRS_I;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      st_ff.np_tx     <= pnpb_pkg::NP_TX_RST;
      st_ff.lp_np     <= pnpb_pkg::LP_NP_RST;
      st_ff.aux       <= pnpb_pkg::AUX_RST;
      st_ff.page_rcvd <= 1'b0;
      st_ff.irq_sts   <= pnpb_pkg::IRQ_RST;
      st_ff.irq_msk   <= pnpb_pkg::IRQ_RST;
      st_ff.prdata    <= 32'h0000_0000;
      st_ff.tx_sym    <= '0;
      st_ff.rx_out    <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign NP_TX_WORD_O       = st_ff.np_tx;

  // Aux control bits, each a plain level straight from the register
  assign tx_disable = st_ff.aux[pnpb_pkg::AUX_TX_DIS_BIT];
  assign byp_scr    = st_ff.aux[pnpb_pkg::AUX_BYP_SCR];
  assign byp_nrzi   = st_ff.aux[pnpb_pkg::AUX_BYP_NRZI];
  assign blw_off    = st_ff.aux[pnpb_pkg::AUX_BLW_OFF];
  assign fef_on     = st_ff.aux[pnpb_pkg::AUX_FEF_BIT];
  assign ext_fifo   = st_ff.aux[pnpb_pkg::AUX_EXT_FIFO];

  // Output enable is active low: high means the line driver floats
  assign LINE_TX_OE_N_O     = tx_disable;
  assign BYPASS_SCRAMBLER_O = byp_scr;
  assign BYPASS_NRZI_O      = byp_nrzi;
  assign BYPASS_ALIGN_O     = bypass_align;
  assign BLW_CORR_OFF_O     = blw_off;
  assign FAR_END_FAULT_ON_O = fef_on;
  assign EXT_RX_FIFO_O      = ext_fifo;

  assign SCR_CODE_O         = st_ff.tx_sym.code;
  assign SCR_VALID_O        = st_ff.tx_sym.valid;
  assign DELIM_INSERT_O     = st_ff.tx_sym.delim_insert;
  assign RXD_O              = st_ff.rx_out.rxd;
  assign RXER_O             = st_ff.rx_out.rxer;
  assign CRS_O              = st_ff.rx_out.crs;

endmodule

`default_nettype wire

// ==== dv/pnpb_regs_assertions.sv ====
// Port-level checks for the next-page and line-coding register bank.
// Assumes software writes whole words with all strobes set.
`timescale 1ns/1ps
`default_nettype none
module pnpb_regs_assertions (
  input wire logic        CLOCK_I,
  input wire logic        RST_N_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0]  PSTRB_I,
  input wire logic        IRQ_O,
  input wire logic        LP_PAGE_VALID_I,
  input wire logic        NP_SENT_I,
  input wire logic [15:0] NP_TX_WORD_O,
  input wire logic        LINE_TX_OE_N_O,
  input wire logic        BYPASS_SCRAMBLER_O,
  input wire logic        BYPASS_NRZI_O,
  input wire logic        BYPASS_ALIGN_O,
  input wire logic        BLW_CORR_OFF_O,
  input wire logic        FAR_END_FAULT_ON_O,
  input wire logic        EXT_RX_FIFO_O
);
  wire wr = PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I == 4'hF;
  wire aux_wr = wr && PADDR_I == 8'h80;
  wire np_wr = wr && PADDR_I == 8'h38;
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  property p_txdis; aux_wr |=> LINE_TX_OE_N_O == $past(PWDATA_I[13]); endproperty
  a_txdis: assert property (p_txdis) else $error("tx disable wrong");
  property p_scr; aux_wr |=> BYPASS_SCRAMBLER_O == $past(PWDATA_I[9]); endproperty
  a_scr: assert property (p_scr) else $error("scrambler bypass wrong");
  property p_nrzi; aux_wr |=> BYPASS_NRZI_O == $past(PWDATA_I[8]); endproperty
  a_nrzi: assert property (p_nrzi) else $error("nrzi bypass wrong");
  property p_blw; aux_wr |=> BLW_CORR_OFF_O == $past(PWDATA_I[6]); endproperty
  a_blw: assert property (p_blw) else $error("wander control wrong");
  property p_aux; aux_wr |=> {BYPASS_ALIGN_O, FAR_END_FAULT_ON_O, EXT_RX_FIFO_O}
    == {$past(PWDATA_I[7]), $past(PWDATA_I[5]), $past(PWDATA_I[2])}; endproperty
  a_aux: assert property (p_aux) else $error("aux control wrong");
  property p_np; np_wr |=> NP_TX_WORD_O[15:12] == {$past(PWDATA_I[15]), 1'b0, $past(PWDATA_I[13:12])}
    && NP_TX_WORD_O[10:0] == $past(PWDATA_I[10:0]); endproperty
  a_np: assert property (p_np) else $error("next page word wrong");
  // Toggle moves only on a sent pulse, never by software
  property p_tog; $past(RST_N_I) |-> NP_TX_WORD_O[11] == ($past(NP_TX_WORD_O[11]) ^ $past(NP_SENT_I)); endproperty
  a_tog: assert property (p_tog) else $error("toggle wrong");
  property p_irq; $rose(IRQ_O) |-> $past(LP_PAGE_VALID_I || NP_SENT_I || wr); endproperty
  a_irq: assert property (p_irq) else $error("interrupt without cause");
  c_aux: cover property (aux_wr);
  c_tog: cover property (NP_SENT_I ##1 NP_TX_WORD_O[11]);
  c_irq: cover property ($rose(IRQ_O));
endmodule
bind pnpb_regs pnpb_regs_assertions pnpb_regs_assertions_inst (.*);
`default_nettype wire

// ==== dv/pnpb_lp_model.sv ====
// Arbiter stand-in delivering partner pages and page-sent pulses.
// Assumes its tasks are called just after a rising edge of clk_i.
`timescale 1ns/1ps
`default_nettype none
module pnpb_lp_model (
  input  wire logic        clk_i,
  output var  logic        page_vld_o,
  output var  logic [15:0] page_o,
  output var  logic        sent_o
);
  initial {page_vld_o, page_o, sent_o} = 18'h00000;
  // Word means nothing outside its pulse, so it is inverted afterwards
  task automatic send_page(input logic [15:0] w);
    page_vld_o <= 1'b1;
    page_o <= w;
    @(posedge clk_i);
    page_vld_o <= 1'b0;
    page_o <= ~w;
  endtask
  task automatic page_sent();
    sent_o <= 1'b1;
    @(posedge clk_i);
    sent_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== dv/pnpb_regs_tb.sv ====
// Self-checking bench for the next-page and line-coding register bank.
// Assumes zero-wait APB answers and one-cycle datapath latency.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin error_cnt++; $display("wrong value at %0t: %h not %h", $time, a, e); end end
module pnpb_regs_tb;
  logic        CLOCK_I, RST_N_I, PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O, IRQ_O, LP_PAGE_VALID_I, NP_SENT_I;
  logic [7:0]  PADDR_I;
  logic [31:0] PWDATA_I, PRDATA_O, rd, v;
  logic [3:0]  PSTRB_I, TXD_I, DEC_RXD_I, RXD_O;
  logic [15:0] LP_PAGE_I, NP_TX_WORD_O;
  logic        LINE_TX_OE_N_O, BYPASS_SCRAMBLER_O, BYPASS_NRZI_O, BYPASS_ALIGN_O, BLW_CORR_OFF_O, FAR_END_FAULT_ON_O;
  logic        EXT_RX_FIFO_O, TXEN_I, TXER_I, ENC_VALID_I, SCR_VALID_O, DELIM_INSERT_O, RX_FRAME_VALID_I;
  logic        DEC_RXER_I, DEC_CRS_I, RXER_O, CRS_O, err;
  logic [4:0]  ENC_CODE_I, SCR_CODE_O, RX_CODE_ALIGNED_I, RX_CODE_RAW_I;
  int          error_cnt = 0, comparisons = 0;
  int          bits[8] = '{13, 10, 9, 8, 7, 6, 5, 2};
  wire  [6:0]  ctl = {LINE_TX_OE_N_O, BYPASS_SCRAMBLER_O, BYPASS_NRZI_O, BYPASS_ALIGN_O,
                      BLW_CORR_OFF_O, FAR_END_FAULT_ON_O, EXT_RX_FIFO_O};
  pnpb_regs pnpb_regs_inst (.*);
  pnpb_lp_model pnpb_lp_model_inst (.clk_i(CLOCK_I), .page_vld_o(LP_PAGE_VALID_I), .page_o(LP_PAGE_I), .sent_o(NP_SENT_I));
  initial begin
    CLOCK_I = 1'b0;
    forever #2.5 CLOCK_I = ~CLOCK_I;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL_I <= 1'b1;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge CLOCK_I);
    PENABLE_I <= 1'b1;
    do begin
      @(posedge CLOCK_I);
    end while (PREADY_O !== 1'b1);
    rd = PRDATA_O;
    err = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
    @(posedge CLOCK_I);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic wrrd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    apb(1'b1, a, d);
    rdchk(a, e);
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    finish_test();
  end
  initial begin
    RST_N_I = 1'b0;
    {PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I, PSTRB_I} = {3'h0, 8'h00, 32'h0, 4'hF};
    {TXEN_I, TXER_I, TXD_I, ENC_CODE_I, ENC_VALID_I} = 12'h000;
    {RX_CODE_ALIGNED_I, RX_CODE_RAW_I, RX_FRAME_VALID_I, DEC_RXD_I, DEC_RXER_I, DEC_CRS_I} = 17'h00000;
    repeat (16) @(posedge CLOCK_I);
    RST_N_I <= 1'b1;
    @(posedge CLOCK_I);
    `CHK(LINE_TX_OE_N_O, 1'b0)
    rdchk(8'h38, 32'h2001);
    rdchk(8'h40, 32'h0);
    rdchk(8'h80, 32'h0);
    wrrd(8'h38, 32'hFFFF, 32'hB7FF);
    `CHK(NP_TX_WORD_O, 16'hB7FF)
    wrrd(8'h38, 32'h0, 32'h0);
    pnpb_lp_model_inst.page_sent();
    rdchk(8'h38, 32'h0800);
    pnpb_lp_model_inst.page_sent();
    rdchk(8'h38, 32'h0);
    pnpb_lp_model_inst.send_page(16'h9ABC);
    wrrd(8'h40, 32'h1234, 32'h9ABC);
    `CHK(IRQ_O, 1'b0)
    apb(1'b0, 8'h30, 32'h0);
    `CHK(rd[1], 1'b1)
    apb(1'b0, 8'h30, 32'h0);
    `CHK(rd[1], 1'b0)
    apb(1'b1, 8'h94, 32'h1);
    @(posedge CLOCK_I);
    `CHK(IRQ_O, 1'b1)
    apb(1'b1, 8'h90, 32'h3);
    @(posedge CLOCK_I);
    `CHK(IRQ_O, 1'b0)
    rdchk(8'h90, 32'h0);
    apb(1'b0, 8'hFC, 32'h0);
    `CHK(err, 1'b1)
    foreach (bits[i]) begin
      v = 32'h1 << bits[i];
      wrrd(8'h80, v, v);
      `CHK(ctl, {v[13], v[9], v[8], v[7], v[6], v[5], v[2]})
    end
    wrrd(8'h80, 32'h0400, 32'h0400);
    {TXEN_I, TXER_I, TXD_I} <= 6'h35;
    {RX_CODE_ALIGNED_I, RX_CODE_RAW_I, RX_FRAME_VALID_I} <= {5'h0A, 5'h13, 1'b1};
    repeat (2) @(posedge CLOCK_I);
    `CHK({SCR_CODE_O, SCR_VALID_O, DELIM_INSERT_O}, 7'h56)
    `CHK({RXER_O, RXD_O, CRS_O}, 6'h15)
    wrrd(8'h80, 32'h0480, 32'h0480);
    `CHK({RXER_O, RXD_O, CRS_O}, 6'h27)
    {ENC_CODE_I, ENC_VALID_I, DEC_RXD_I, DEC_CRS_I} <= {5'h0E, 1'b1, 4'h6, 1'b1};
    wrrd(8'h80, 32'h0, 32'h0);
    `CHK({SCR_CODE_O, SCR_VALID_O, DELIM_INSERT_O}, 7'h3B)
    `CHK({RXER_O, RXD_O, CRS_O}, 6'h0D)
    finish_test();
  end
endmodule
`default_nettype wire
